/* common/timer_defs.svh */
// Offsets, field positions, reset values and encodings of the main timer core.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define ADDR_W 8
`define OFF_CTRL_A 8'h00
`define OFF_CTRL_B 8'h04
`define OFF_STROBES 8'h08
`define OFF_COUNT 8'h0c
`define OFF_PERIOD 8'h10
`define OFF_CHAN_MODE 8'h14
`define OFF_STATUS 8'h18
`define OFF_CHAN_BASE 8'h1c
`define CHAN_STRIDE 8'h04

`define CA_DIV_LSB 0
`define CA_PRE_BIT 3
`define CA_RUN_BIT 4
`define CA_DIR_BIT 5
`define CA_ALIGN_BIT 6
`define CA_STE_BIT 7

`define CB_SSHOT_BIT 0
`define CB_EDGE_LSB 1
`define CB_ISEL_LSB 3

`define SB_RUN_SET 0
`define SB_RUN_CLEAR 1
`define SB_COUNTER_CLEAR 2
`define SB_STE_SET 3
`define SB_STE_CLEAR 4
`define SB_SW_COUNT 5

`define STS_ZERO_BIT 3
`define STS_ONE_BIT 4
`define STS_PERIOD_BIT 5

`define ISEL_TIMER 2'h0
`define ISEL_SW 2'h1
`define ISEL_RISE 2'h2
`define ISEL_FALL 2'h3

`define EDGE_RISE_BIT 0
`define EDGE_FALL_BIT 1

`define EXTRA_PRESCALE_SHIFT 4'h8
`define COUNT_RESET 16'h0000
`define PERIOD_RESET 16'h0000

`endif

/* common/timer_pkg.sv */
// Types shared by the main timer core, its assertions and its bench.
package timer_pkg;

  typedef struct packed {
    logic [1:0] input_sel;
    logic [1:0] start_edge;
    logic single_shot;
    logic align;
    logic extra_pre;
    logic [2:0] div_sel;
  } timer_cfg_t;

  typedef struct packed {
    logic period;
    logic one;
    logic zero;
  } match_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

/* design/presc_divider.sv */
// Module clock prescaler that produces the counting tick in timer mode.
`timescale 1ns/100ps
`include "timer_defs.svh"
module presc_divider #(
  parameter int PRESC_W = 15
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic run,
  input wire logic [2:0] div_sel,
  input wire logic extra_pre,
  output logic tick
);
  logic [PRESC_W-1:0] count;
  logic [PRESC_W-1:0] next_count;
  logic [PRESC_W-1:0] mask;
  logic [3:0] shift;

  // Held at zero while stopped so the first tick after a start is always a full period.
  always_comb begin
    next_count = run ? PRESC_W'(count + 1'b1) : '0;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count <= '0;
    end else if (clk_en) begin
      count <= next_count;
    end
  end

  always_comb begin
    shift = {1'b0, div_sel} + (extra_pre ? `EXTRA_PRESCALE_SHIFT : 4'h0);
    mask = PRESC_W'((PRESC_W'(1) << shift) - 1'b1);
    tick = run & (&(count | ~mask));
  end
endmodule

/* design/cc_channel.sv */
// One capture/compare channel register with shadow, comparator and capture input.
`timescale 1ns/100ps
`include "timer_defs.svh"
module cc_channel #(
  parameter int COUNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [COUNT_W-1:0] count,
  input wire logic shadow_write,
  input wire logic [COUNT_W-1:0] write_data,
  input wire logic shadow_load,
  input wire logic capture_mode,
  input wire logic capture_pin,
  output logic [COUNT_W-1:0] value,
  output logic match
);
  logic [2:0] pin_sync;
  logic [2:0] next_pin_sync;
  logic [COUNT_W-1:0] shadow;
  logic [COUNT_W-1:0] next_shadow;
  logic [COUNT_W-1:0] next_value;

  // Stage 0 only feeds stage 1; edges are taken between stages 1 and 2.
  always_comb begin
    next_pin_sync = {pin_sync[1:0], capture_pin};
    next_shadow = shadow_write ? write_data : shadow;
    next_value = value;
    if (capture_mode) begin
      if (pin_sync[1] & ~pin_sync[2]) begin
        next_value = count;
      end
    end else if (shadow_load) begin
      next_value = shadow;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_sync <= '0;
      shadow <= '0;
      value <= '0;
    end else if (clk_en) begin
      pin_sync <= next_pin_sync;
      shadow <= next_shadow;
      value <= next_value;
    end
  end

  assign match = ~capture_mode & (count == value);
endmodule

/* design/pwm_main_timer_core.sv */
// Main 16-bit timer core of the capture/compare unit with register port.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "timer_defs.svh"
// Behaviour
// - Count from prescaled module clock or input.
// - Edge-aligned counts up, wraps after period.
// - Center-aligned turns down after period, one beyond.
// - Period match whenever counter equals period.
// - Period reads active, writes go to shadow.
// - Shadow moves to period on transfer pulse.
// - Transfer enable set/cleared by bits, cleared by transfer.
// - One and period matches steer counting.
// - Direction flag shows up or down.
// - One bit selects edge or center alignment.
// - Single shot stops at period end.
// - Run set/cleared by software, edge, hardware.
// - Counter clear resets count only.
// - Count writes ignored while running.
// - Stopped and dead-time idle: writes apply.
// - Three channels, each capture or compare.
// - Divide by two to the code, optional 256.
// - Prescaler held cleared while stopped.
// - One match counting down turns up.
// - Counter mode steps on strobe or edge.
module pwm_main_timer_core
  import timer_pkg::*;
#(
  parameter int COUNT_W = 16,
  parameter int CHANNELS = 3
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire reg_req_t bus_req,
  output logic [31:0] read_data,
  input wire logic external_event_input,
  input wire logic dead_time_idle,
  input wire logic [CHANNELS-1:0] capture_pin,
  output logic run_flag,
  output logic count_direction,
  output logic shadow_transfer_pulse,
  output match_t match_flags,
  output logic [COUNT_W-1:0] main_counter,
  output logic [CHANNELS-1:0] channel_match
);
  timer_cfg_t cfg;
  timer_cfg_t next_cfg;
  logic shadow_transfer_enable;
  logic next_shadow_transfer_enable;
  logic next_run_flag;
  logic next_count_direction;
  logic [COUNT_W-1:0] next_main_counter;
  logic [COUNT_W-1:0] period_value;
  logic [COUNT_W-1:0] next_period_value;
  logic [COUNT_W-1:0] period_shadow;
  logic [COUNT_W-1:0] next_period_shadow;
  logic [CHANNELS-1:0] chan_mode;
  logic [CHANNELS-1:0] next_chan_mode;
  logic [31:0] next_read_data;
  logic [2:0] ext_sync;
  logic [2:0] next_ext_sync;

  logic presc_tick;
  logic ext_rise;
  logic ext_fall;
  logic step_source;
  logic step;
  logic end_of_period;
  logic start_event;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_strobes;
  logic wr_count;
  logic wr_period;
  logic wr_mode;
  logic run_set;
  logic run_clear;
  logic counter_clear;
  logic shadow_enable_set;
  logic shadow_enable_clear;
  logic software_count_strobe;
  logic [CHANNELS-1:0] chan_write;
  logic [COUNT_W-1:0] chan_value [CHANNELS];

  presc_divider u_presc (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .run(run_flag),
    .div_sel(cfg.div_sel),
    .extra_pre(cfg.extra_pre),
    .tick(presc_tick)
  );

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      assign chan_write[ch] = bus_req.wr &&
        (bus_req.addr == 8'(`OFF_CHAN_BASE + ch * `CHAN_STRIDE));
      cc_channel #(
        .COUNT_W(COUNT_W)
      ) u_chan (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .count(main_counter),
        .shadow_write(chan_write[ch]),
        .write_data(bus_req.wdata[COUNT_W-1:0]),
        .shadow_load(shadow_transfer_pulse),
        .capture_mode(chan_mode[ch]),
        .capture_pin(capture_pin[ch]),
        .value(chan_value[ch]),
        .match(channel_match[ch])
      );
    end
  endgenerate

  // Write decode and the write-only strobe bits.
  always_comb begin
    wr_ctrl_a = bus_req.wr && (bus_req.addr == `OFF_CTRL_A);
    wr_ctrl_b = bus_req.wr && (bus_req.addr == `OFF_CTRL_B);
    wr_strobes = bus_req.wr && (bus_req.addr == `OFF_STROBES);
    wr_count = bus_req.wr && (bus_req.addr == `OFF_COUNT);
    wr_period = bus_req.wr && (bus_req.addr == `OFF_PERIOD);
    wr_mode = bus_req.wr && (bus_req.addr == `OFF_CHAN_MODE);
    run_set = wr_strobes & bus_req.wdata[`SB_RUN_SET];
    run_clear = wr_strobes & bus_req.wdata[`SB_RUN_CLEAR];
    counter_clear = wr_strobes & bus_req.wdata[`SB_COUNTER_CLEAR];
    shadow_enable_set = wr_strobes & bus_req.wdata[`SB_STE_SET];
    shadow_enable_clear = wr_strobes & bus_req.wdata[`SB_STE_CLEAR];
    software_count_strobe = wr_strobes & bus_req.wdata[`SB_SW_COUNT];
  end

  // Match detection, step selection and shadow transfer generation.
  always_comb begin
    match_flags.zero = (main_counter == '0);
    match_flags.one = (main_counter == COUNT_W'(1));
    match_flags.period = (main_counter == period_value);
    ext_rise = ext_sync[1] & ~ext_sync[2];
    ext_fall = ~ext_sync[1] & ext_sync[2];
    unique case (cfg.input_sel)
      `ISEL_TIMER: step_source = presc_tick;
      `ISEL_SW: step_source = software_count_strobe;
      `ISEL_RISE: step_source = ext_rise;
      `ISEL_FALL: step_source = ext_fall;
    endcase
    step = run_flag & step_source;
    // Center mode ends its period on the step from one down to zero.
    end_of_period = cfg.align ? (count_direction & match_flags.one) : match_flags.period;
    start_event = (cfg.start_edge[`EDGE_RISE_BIT] & ext_rise) |
                  (cfg.start_edge[`EDGE_FALL_BIT] & ext_fall);
    // While stopped an armed transfer happens at once, so a new setup takes effect before start.
    shadow_transfer_pulse = shadow_transfer_enable &
                            (~run_flag | (step & end_of_period));
  end

  // Next-state computation for the counter, direction, run and configuration.
  always_comb begin
    next_ext_sync = {ext_sync[1:0], external_event_input};
    next_cfg = cfg;
    if (wr_ctrl_a) begin
      next_cfg.div_sel = bus_req.wdata[`CA_DIV_LSB +: 3];
      next_cfg.extra_pre = bus_req.wdata[`CA_PRE_BIT];
      next_cfg.align = bus_req.wdata[`CA_ALIGN_BIT];
    end
    if (wr_ctrl_b) begin
      next_cfg.single_shot = bus_req.wdata[`CB_SSHOT_BIT];
      next_cfg.start_edge = bus_req.wdata[`CB_EDGE_LSB +: 2];
      next_cfg.input_sel = bus_req.wdata[`CB_ISEL_LSB +: 2];
    end
    next_chan_mode = wr_mode ? bus_req.wdata[CHANNELS-1:0] : chan_mode;

    next_period_shadow = wr_period ? bus_req.wdata[COUNT_W-1:0] : period_shadow;
    next_period_value = shadow_transfer_pulse ? period_shadow : period_value;

    // The hardware clear of the enable after a transfer loses to a set in the same cycle.
    next_shadow_transfer_enable = shadow_transfer_enable;
    if (shadow_transfer_pulse | shadow_enable_clear) begin
      next_shadow_transfer_enable = 1'b0;
    end
    if (shadow_enable_set) begin
      next_shadow_transfer_enable = 1'b1;
    end

    next_run_flag = run_flag;
    if (step & end_of_period & cfg.single_shot) begin
      next_run_flag = 1'b0;
    end
    if (run_clear) begin
      next_run_flag = 1'b0;
    end
    if (run_set | start_event) begin
      next_run_flag = 1'b1;
    end

    next_count_direction = count_direction;
    next_main_counter = main_counter;
    // A down direction left over from center mode must not survive a switch to edge mode.
    if (!cfg.align) begin
      next_count_direction = 1'b0;
    end
    if (step) begin
      if (!cfg.align) begin
        next_count_direction = 1'b0;
        next_main_counter = match_flags.period ? '0 : COUNT_W'(main_counter + 1'b1);
      end else begin
        next_main_counter = count_direction ? COUNT_W'(main_counter - 1'b1)
                                            : COUNT_W'(main_counter + 1'b1);
        if (!count_direction && match_flags.period) begin
          next_count_direction = 1'b1;
        end else if (count_direction && match_flags.one) begin
          next_count_direction = 1'b0;
        end
      end
    end
    if (wr_count && !run_flag && dead_time_idle) begin
      next_main_counter = bus_req.wdata[COUNT_W-1:0];
    end
    // A write while running falls through untouched.
    if (counter_clear) begin
      next_main_counter = '0;
    end
  end

  // Registered read port: data stands in the cycle after the read strobe.
  always_comb begin
    next_read_data = '0;
    if (bus_req.rd) begin
      if (bus_req.addr == `OFF_CTRL_A) begin
        next_read_data[`CA_DIV_LSB +: 3] = cfg.div_sel;
        next_read_data[`CA_PRE_BIT] = cfg.extra_pre;
        next_read_data[`CA_RUN_BIT] = run_flag;
        next_read_data[`CA_DIR_BIT] = count_direction;
        next_read_data[`CA_ALIGN_BIT] = cfg.align;
        next_read_data[`CA_STE_BIT] = shadow_transfer_enable;
      end else if (bus_req.addr == `OFF_CTRL_B) begin
        next_read_data[`CB_SSHOT_BIT] = cfg.single_shot;
        next_read_data[`CB_EDGE_LSB +: 2] = cfg.start_edge;
        next_read_data[`CB_ISEL_LSB +: 2] = cfg.input_sel;
      end else if (bus_req.addr == `OFF_COUNT) begin
        next_read_data[COUNT_W-1:0] = main_counter;
      end else if (bus_req.addr == `OFF_PERIOD) begin
        next_read_data[COUNT_W-1:0] = period_value;
      end else if (bus_req.addr == `OFF_CHAN_MODE) begin
        next_read_data[CHANNELS-1:0] = chan_mode;
      end else if (bus_req.addr == `OFF_STATUS) begin
        next_read_data[CHANNELS-1:0] = channel_match;
        next_read_data[`STS_ZERO_BIT] = match_flags.zero;
        next_read_data[`STS_ONE_BIT] = match_flags.one;
        next_read_data[`STS_PERIOD_BIT] = match_flags.period;
      end else begin
        for (int i = 0; i < CHANNELS; i++) begin
          if (bus_req.addr == 8'(`OFF_CHAN_BASE + i * `CHAN_STRIDE)) begin
            next_read_data[COUNT_W-1:0] = chan_value[i];
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg <= '0;
      chan_mode <= '0;
      shadow_transfer_enable <= 1'b0;
      run_flag <= 1'b0;
      count_direction <= 1'b0;
      main_counter <= `COUNT_RESET;
      period_value <= `PERIOD_RESET;
      period_shadow <= `PERIOD_RESET;
      read_data <= '0;
      ext_sync <= '0;
    end else if (clk_en) begin
      cfg <= next_cfg;
      chan_mode <= next_chan_mode;
      shadow_transfer_enable <= next_shadow_transfer_enable;
      run_flag <= next_run_flag;
      count_direction <= next_count_direction;
      main_counter <= next_main_counter;
      period_value <= next_period_value;
      period_shadow <= next_period_shadow;
      read_data <= next_read_data;
      ext_sync <= next_ext_sync;
    end
  end
endmodule

/* sim/timer_core_sva.sv */
// Port-level assertions for the main timer core.
`timescale 1ns/100ps
`include "timer_defs.svh"
module timer_core_sva
  import timer_pkg::*;
#(
  parameter int COUNT_W = 16,
  parameter int CHANNELS = 3
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire reg_req_t bus_req,
  input wire logic [31:0] read_data,
  input wire logic external_event_input,
  input wire logic dead_time_idle,
  input wire logic [CHANNELS-1:0] capture_pin,
  input wire logic run_flag,
  input wire logic count_direction,
  input wire logic shadow_transfer_pulse,
  input wire match_t match_flags,
  input wire logic [COUNT_W-1:0] main_counter,
  input wire logic [CHANNELS-1:0] channel_match
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic cnt_wr;
  logic strobe_wr;
  logic [15:0] wval;
  assign cnt_wr = bus_req.wr && bus_req.addr == `OFF_COUNT;
  assign strobe_wr = bus_req.wr && bus_req.addr == `OFF_STROBES;
  assign wval = bus_req.wdata[15:0];
  sequence s_one_down;
    count_direction && match_flags.one && clk_en;
  endsequence
  sequence s_reach_zero;
    match_flags.zero;
  endsequence
  property p_zero;
    match_flags.zero == (main_counter == 16'h0000);
  endproperty
  a_zero: assert property (p_zero) else $error("zero match wrong");
  property p_one;
    match_flags.one == (main_counter == 16'h0001);
  endproperty
  a_one: assert property (p_one) else $error("one match wrong");
  property p_turn_up;
    s_one_down ##1 s_reach_zero |-> !count_direction;
  endproperty
  a_turn_up: assert property (p_turn_up) else $error("no turn up at zero");
  property p_down_step;
    count_direction && clk_en && !bus_req.wr |=>
      main_counter == $past(main_counter) || main_counter == $past(main_counter) - 16'h1;
  endproperty
  a_down_step: assert property (p_down_step) else $error("bad down step");
  property p_edge_wrap;
    !count_direction && match_flags.period && run_flag && clk_en && !bus_req.wr |=>
      main_counter == $past(main_counter) || main_counter == 16'h0 || count_direction;
  endproperty
  a_edge_wrap: assert property (p_edge_wrap) else $error("bad period end");
  property p_hold_stopped;
    !run_flag && clk_en && !bus_req.wr |=> $stable(main_counter);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("stopped count moved");
  property p_write_refused;
    run_flag && cnt_wr && wval != main_counter + 16'h1 && wval != main_counter - 16'h1 &&
      wval != 16'h0 && wval != main_counter |=> main_counter != $past(wval);
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("write while running");
  property p_write_taken;
    !run_flag && dead_time_idle && cnt_wr && clk_en |=> main_counter == $past(wval);
  endproperty
  a_write_taken: assert property (p_write_taken) else $error("count write lost");
  property p_clear;
    strobe_wr && bus_req.wdata[2] && !bus_req.wdata[1] && !bus_req.wdata[0] && clk_en |=>
      main_counter == 16'h0 && run_flag == $past(run_flag);
  endproperty
  a_clear: assert property (p_clear) else $error("counter clear wrong");
  property p_pulse_once;
    shadow_transfer_pulse |=> !shadow_transfer_pulse;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("transfer pulse repeats");
  property p_read_idle;
    !bus_req.rd && clk_en |=> read_data == 32'h0;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data without read");
  property p_reset_state;
    $fell(reset) |-> main_counter == 16'h0 && !run_flag && !count_direction;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
endmodule
bind pwm_main_timer_core timer_core_sva #(.COUNT_W(COUNT_W), .CHANNELS(CHANNELS)) sva_u (
  .sys_clk, .reset, .clk_en, .bus_req, .read_data, .external_event_input, .dead_time_idle,
  .capture_pin, .run_flag, .count_direction, .shadow_transfer_pulse, .match_flags,
  .main_counter, .channel_match);

/* sim/event_source.sv */
// Model of the external event pin that feeds the timer.
`timescale 1ns/100ps
module event_source (
  input wire logic sys_clk,
  output logic external_event_input
);
  initial external_event_input = 1'b0;
  // Each level is held four cycles so the two-flop synchroniser sees both edges.
  task automatic pulse();
    @(posedge sys_clk);
    external_event_input <= 1'b1;
    repeat (4) @(posedge sys_clk);
    external_event_input <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

/* sim/pwm_main_timer_core_bench.sv */
// Self-checking bench for the main timer core.
`timescale 1ns/100ps
`include "timer_defs.svh"
module pwm_main_timer_core_bench;
  import timer_pkg::*;
  logic sys_clk, reset, dead_time_idle, ext_in;
  reg_req_t bus_req;
  logic [2:0] capture_pin, channel_match;
  logic [31:0] read_data, d;
  logic run_flag, count_direction, shadow_transfer_pulse;
  match_t match_flags;
  logic [15:0] main_counter;
  int n_mismatch, n_compared, cyc, p, v;
  pwm_main_timer_core dut_u (.sys_clk, .reset, .clk_en(1'b1), .bus_req, .read_data,
    .external_event_input(ext_in), .dead_time_idle, .capture_pin, .run_flag,
    .count_direction, .shadow_transfer_pulse, .match_flags, .main_counter, .channel_match);
  event_source src_u (.sys_clk, .external_event_input(ext_in));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task give_verdict();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task clk(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task wr(logic [7:0] a, logic [31:0] w);
    @(posedge sys_clk);
    bus_req <= '{a, w, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_req <= '{a, w, 1'b0, 1'b0};
    #1;
  endtask
  task rd(logic [7:0] a, output logic [31:0] q);
    @(posedge sys_clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b0};
    #1;
    q = read_data;
  endtask
  task sb(int b);
    wr(`OFF_STROBES, 32'h1 << b);
  endtask
  // Integer model of the counter at divide-by-1, aligned on the first step.
  task track(int n, int ctr, int ss);
    int c, dr, on, k;
    c = 1;
    dr = 0;
    on = 1;
    k = 0;
    while (main_counter !== 16'h1 && k < 20) begin
      clk(1);
      k++;
    end
    repeat (n) begin
      chk(main_counter, c);
      chk(count_direction, dr);
      chk(run_flag, on);
      if (!on) k = 0;
      else if (!ctr) begin
        on = (c == p) ? !ss : 1;
        c = (c == p) ? 0 : c + 1;
      end else if (!dr) begin
        dr = (c == p);
        c++;
      end else begin
        dr = (c != 1);
        c--;
      end
      clk(1);
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    capture_pin <= $urandom;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    v = $urandom(15461);
    reset = 1'b1;
    dead_time_idle = 1'b1;
    capture_pin = 3'h0;
    bus_req = '0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    clk(1);
    chk(main_counter, 0);
    rd(`OFF_CTRL_A, d);
    chk(d, 0);
    wr(`OFF_CTRL_A, 32'hb0);
    rd(`OFF_CTRL_A, d);
    chk(d, 0);
    rd(8'hfc, d);
    chk(d, 0);
    p = 2 + $urandom % 6;
    wr(`OFF_PERIOD, p);
    rd(`OFF_PERIOD, d);
    chk(d, 0);
    sb(`SB_STE_SET);
    rd(`OFF_PERIOD, d);
    chk(d, p);
    rd(`OFF_CTRL_A, d);
    chk(d, 0);
    // Center-aligned goes last; with a period of 2 or 3 it stops with direction down, cleared by the later switch to edge mode.
    for (int m = 0; m < 3; m++) begin
      wr(`OFF_CTRL_A, m == 2 ? 32'h40 : 32'h0);
      wr(`OFF_CTRL_B, m == 1);
      sb(`SB_RUN_SET);
      track(4 * p + 5, m == 2, m == 1);
      sb(`SB_RUN_CLEAR);
      sb(`SB_COUNTER_CLEAR);
    end
    wr(`OFF_PERIOD, 32'hffff);
    sb(`SB_STE_SET);
    wr(`OFF_CTRL_B, 0);
    for (int k = 0; k < 9; k++) begin
      wr(`OFF_CTRL_A, k < 8 ? k : 32'h8);
      sb(`SB_COUNTER_CLEAR);
      sb(`SB_RUN_SET);
      v = 0;
      while (main_counter !== 16'h1 && v < 300) begin
        clk(1);
        v++;
      end
      chk(v, k < 8 ? 1 << k : 256);
      v = 0;
      while (main_counter === 16'h1 && v < 300) begin
        clk(1);
        v++;
      end
      chk(v, k < 8 ? 1 << k : 256);
      sb(`SB_RUN_CLEAR);
    end
    sb(`SB_RUN_SET);
    for (int i = 1; i < 4; i++) begin
      wr(`OFF_CTRL_B, i << 3);
      sb(`SB_COUNTER_CLEAR);
      repeat (i + 1) if (i == 1) sb(`SB_SW_COUNT); else src_u.pulse();
      clk(4);
      chk(main_counter, i + 1);
      wr(`OFF_COUNT, 32'h1234);
      chk(main_counter, i + 1);
    end
    sb(`SB_COUNTER_CLEAR);
    chk(main_counter, 0);
    chk(run_flag, 1);
    for (int j = 1; j < 3; j++) begin
      sb(`SB_RUN_CLEAR);
      chk(run_flag, 0);
      wr(`OFF_CTRL_B, j << 1);
      src_u.pulse();
      clk(2);
      chk(run_flag, 1);
    end
    sb(`SB_RUN_CLEAR);
    v = $urandom % 65536;
    wr(`OFF_COUNT, v);
    chk(main_counter, v);
    @(posedge sys_clk);
    dead_time_idle <= 1'b0;
    wr(`OFF_COUNT, v ^ 16'hffff);
    chk(main_counter, v);
    wr(`OFF_CHAN_BASE, v);
    sb(`SB_STE_SET);
    rd(`OFF_CHAN_BASE, d);
    chk(d, v);
    chk(channel_match, v == 0 ? 32'h7 : 32'h1);
    give_verdict();
  end
endmodule
